// ### cache_bus_unit.v
// Control registers, cache timing and write-path glue of the external cache bus unit.
`timescale 1ns/1ps
`include "cache_bus_unit_regs.vh"

module cache_bus_unit #(
    parameter TAG_W = 15
) (
    // Clock and reset.
    input wire i_sys_clk,
    input wire i_reset,
    // Processor register port.
    input wire i_reg_wr,
    input wire i_reg_rd,
    input wire [7:0] i_reg_addr,
    input wire [31:0] i_reg_wdata,
    output reg [31:0] o_reg_rdata,
    // Write request from the write path.
    input wire i_wr_req,
    input wire [15:0] i_wr_byte_mask,
    input wire i_wr_is_io,
    input wire i_wr_is_unlock,
    input wire i_wr_qw_queued,
    output reg o_wr_probe,
    output reg o_wr_block_write,
    output reg o_pack_next,
    // Read request and tag probe.
    input wire i_rd_req,
    output reg o_rd_probe,
    input wire i_tag_probe_done,
    input wire [TAG_W-1:0] i_tag_probe_value,
    input wire [5:0] i_req_tag_bits,
    input wire [5:0] i_ram_tag_bits,
    output reg o_tag_upper_match,
    // Error events.
    input wire i_err_hard,
    input wire i_err_soft,
    input wire i_err_tag_par,
    input wire i_err_tagctl_par,
    input wire i_err_fill_ecc,
    input wire i_err_fill_crd,
    input wire i_err_fill_par,
    input wire [13:0] i_fill_syndrome,
    // Store conditional and fetch lockout.
    input wire i_stxc_done,
    input wire i_stxc_failed,
    input wire i_lock_read_failed,
    output reg o_fetch_lockout,
    // Check bits for write data.
    input wire [13:0] i_gen_check_bits,
    output reg [13:0] o_write_check_bits,
    // External pins (check inputs come from off chip).
    input wire [27:0] i_check_pins,
    output reg [7:0] o_write_byte_mask_pins,
    output reg o_data_address_bit,
    output reg [1:0] o_data_write_enable_pins,
    output reg [3:0] o_longword_parity,
    output reg o_cache_cycle_enable,
    output reg [3:0] o_cache_size_kb_log
);

////////////////////////////////////////////////////////////////////////////////

// Register state.
reg [31:0] ctl_ff;
reg [14:0] stat_ff;
reg [13:0] syn_ff;
reg [13:0] swck_ff;
reg [TAG_W-1:0] tag_ff;
reg stxc_ff;
reg pack_ff;
reg [1:0] pack_cnt_ff;
reg [27:0] chk_s1_ff;
reg [27:0] chk_s2_ff;
reg [1:0] spd_cnt_ff;
// Next values of the pack request.
reg nxt_pack_ff;
reg [1:0] nxt_pack_cnt_ff;

wire low_cost = ctl_ff[`CTL_LOW_COST_BIT];
wire [1:0] spd = ctl_ff[`CTL_SPD_HI:`CTL_SPD_LO];
wire [2:0] size = ctl_ff[`CTL_SIZE_HI:`CTL_SIZE_LO];
wire wr_ctl = i_reg_wr && (i_reg_addr == `REG_BUS_UNIT_CONTROL);
wire wr_stat = i_reg_wr && (i_reg_addr == `REG_BUS_UNIT_ERROR_STATUS);
wire [31:0] w1c = wr_stat ? i_reg_wdata : 32'h00000000;
wire biu_locked = stat_ff[`STAT_HERR] | stat_ff[`STAT_SERR] | stat_ff[`STAT_TPERR] | stat_ff[`STAT_TCPERR];
wire fill_locked = stat_ff[`STAT_FILL_ECC] | stat_ff[`STAT_DPERR];
wire tag_locked = biu_locked | fill_locked;
wire fill_err_any = i_err_fill_ecc | i_err_fill_par;
wire pack_set = i_reg_wr && (i_reg_addr == `REG_QUADWORD_PACK_REQUEST_REQUEST);

// Last cycle count of a cache access for a speed code.
function [1:0] spd_last;
    input [1:0] code;
    begin
        case (code)
            `SPD_2X: spd_last = 2'h1;
            `SPD_3X: spd_last = 2'h2;
            `SPD_4X: spd_last = 2'h3;
            default: spd_last = 2'h1;
        endcase
    end
endfunction

// Number of tag bits 22:17 that do not take part in the match for a size code.
// The unused code 111 is treated as the largest size, so the decode never selects
// more index bits than the tag pins provide.
function [2:0] tag_skip;
    input [2:0] code;
    begin
        tag_skip = (code > 3'h6) ? 3'h6 : code;
    end
endfunction

////////////////////////////////////////////////////////////////////////////////

// Control register and store-conditional outcome; cleared on reset.
always @(posedge i_sys_clk) begin
    if (i_reset) begin
        ctl_ff <= `CTL_RESET;
        stxc_ff <= 1'b0;
    end else begin
        if (wr_ctl)
            ctl_ff <= i_reg_wdata;
        if (i_stxc_done)
            stxc_ff <= i_stxc_failed;
    end
end

// Error status: events set, write-one clears, set wins over clear.
always @(posedge i_sys_clk) begin
    if (i_reset) begin
        stat_ff <= 15'h0000;
    end else begin
        stat_ff[`STAT_HERR] <= i_err_hard | (stat_ff[`STAT_HERR] & ~w1c[`STAT_HERR]);
        stat_ff[`STAT_SERR] <= i_err_soft | (stat_ff[`STAT_SERR] & ~w1c[`STAT_SERR]);
        stat_ff[`STAT_TPERR] <= i_err_tag_par | (stat_ff[`STAT_TPERR] & ~w1c[`STAT_TPERR]);
        stat_ff[`STAT_TCPERR] <= i_err_tagctl_par | (stat_ff[`STAT_TCPERR] & ~w1c[`STAT_TCPERR]);
        stat_ff[`STAT_BIU_SEO] <= ((i_err_hard | i_err_tag_par | i_err_tagctl_par) & biu_locked) |
            (stat_ff[`STAT_BIU_SEO] & ~w1c[`STAT_BIU_SEO]);
        stat_ff[`STAT_FILL_ECC] <= i_err_fill_ecc | (stat_ff[`STAT_FILL_ECC] & ~w1c[`STAT_FILL_ECC]);
        stat_ff[`STAT_FILL_CRD] <= (i_err_fill_ecc & ~fill_locked) ? i_err_fill_crd :
            (stat_ff[`STAT_FILL_CRD] & ~w1c[`STAT_FILL_CRD]);
        stat_ff[`STAT_DPERR] <= i_err_fill_par | (stat_ff[`STAT_DPERR] & ~w1c[`STAT_DPERR]);
        stat_ff[`STAT_FILL_SEO] <= (fill_err_any & fill_locked) | (stat_ff[`STAT_FILL_SEO] & ~w1c[`STAT_FILL_SEO]);
        stat_ff[6:4] <= 3'h0;
        stat_ff[13:11] <= 3'h0;
    end
end

// Fill syndrome: captured on an ECC fill error while ECC is enabled and unlocked, held until cleared.
always @(posedge i_sys_clk) begin
    if (i_reset) begin
        syn_ff <= 14'h0000;
    end else if (i_err_fill_ecc && ctl_ff[`CTL_ECC_BIT] && !fill_locked) begin
        syn_ff <= i_fill_syndrome;
    end
end

// Tag capture follows each probe until an error locks it. Reads never change it.
always @(posedge i_sys_clk) begin
    if (i_reset) begin
        tag_ff <= {TAG_W{1'b0}};
    end else if (i_tag_probe_done && !tag_locked && !i_err_tag_par && !i_err_tagctl_par && !fill_err_any) begin
        tag_ff <= i_tag_probe_value;
    end
end

// Software check bits register, write only.
always @(posedge i_sys_clk) begin
    if (i_reset)
        swck_ff <= 14'h0000;
    else if (i_reg_wr && (i_reg_addr == `REG_SW_CHECK_BITS))
        swck_ff <= i_reg_wdata[13:0];
end

// Next value of the quadword pack request: a write sets it and restarts the longword count,
// the queue load of the packed quadword clears it, and a set in that same cycle wins.
always @* begin
    nxt_pack_ff = pack_ff;
    nxt_pack_cnt_ff = pack_cnt_ff;
    if (pack_set) begin
        nxt_pack_ff = 1'b1;
        nxt_pack_cnt_ff = 2'h0;
    end else if (pack_ff && i_wr_qw_queued) begin
        nxt_pack_ff = 1'b0;
    end else if (pack_ff && i_wr_req && (pack_cnt_ff != 2'h2)) begin
        nxt_pack_cnt_ff = pack_cnt_ff + 2'h1;
    end
end

// Quadword pack request registers; the two longwords that follow it are counted.
always @(posedge i_sys_clk) begin
    if (i_reset) begin
        pack_ff <= 1'b0;
        pack_cnt_ff <= 2'h0;
    end else begin
        pack_ff <= nxt_pack_ff;
        pack_cnt_ff <= nxt_pack_cnt_ff;
    end
end

// Fetch lockout: set by failed locked read, cleared by any write to AC.
always @(posedge i_sys_clk) begin
    if (i_reset)
        o_fetch_lockout <= 1'b0;
    else if (i_lock_read_failed)
        o_fetch_lockout <= 1'b1;
    else if (i_reg_wr && (i_reg_addr == `REG_STORE_COND_OUTCOME))
        o_fetch_lockout <= 1'b0;
end

////////////////////////////////////////////////////////////////////////////////

// Check pins are off chip: two-stage synchroniser.
always @(posedge i_sys_clk) begin
    if (i_reset) begin
        chk_s1_ff <= 28'h0000000;
        chk_s2_ff <= 28'h0000000;
    end else begin
        chk_s1_ff <= i_check_pins;
        chk_s2_ff <= chk_s1_ff;
    end
end

// Longword parity from byte parity inputs in low-cost mode.
always @(posedge i_sys_clk) begin
    if (i_reset)
        o_longword_parity <= 4'h0;
    else if (low_cost)
        o_longword_parity <= {^chk_s2_ff[24:21], ^chk_s2_ff[17:14], ^chk_s2_ff[10:7], ^chk_s2_ff[3:0]};
    else
        o_longword_parity <= 4'h0;
end

// Cache cycle enable: one pulse per cache access period.
always @(posedge i_sys_clk) begin
    if (i_reset) begin
        spd_cnt_ff <= 2'h0;
        o_cache_cycle_enable <= 1'b0;
    end else if (spd_cnt_ff >= spd_last(spd)) begin
        spd_cnt_ff <= 2'h0;
        o_cache_cycle_enable <= 1'b1;
    end else begin
        spd_cnt_ff <= spd_cnt_ff + 2'h1;
        o_cache_cycle_enable <= 1'b0;
    end
end

// Size decode (log2 of Kbytes: 7 is 128K) and upper tag match over bits 22:17.
// Each doubling of the cache moves one more low tag bit into the index, so the match
// loses bit 17 first and bit 22 last; the compare mask moves towards bit 22.
always @(posedge i_sys_clk) begin
    if (i_reset) begin
        o_cache_size_kb_log <= 4'h7;
        o_tag_upper_match <= 1'b0;
    end else begin
        o_cache_size_kb_log <= 4'h7 + {1'b0, tag_skip(size)};
        o_tag_upper_match <= ((i_req_tag_bits ^ i_ram_tag_bits) & (6'h3f << tag_skip(size))) == 6'h00;
    end
end

////////////////////////////////////////////////////////////////////////////////

// Write and read routing plus mask pins.
always @(posedge i_sys_clk) begin
    if (i_reset) begin
        o_wr_probe <= 1'b0;
        o_wr_block_write <= 1'b0;
        o_rd_probe <= 1'b0;
        o_write_byte_mask_pins <= 8'h00;
        o_data_address_bit <= 1'b0;
        o_data_write_enable_pins <= 2'h0;
        o_pack_next <= 1'b0;
    end else begin
        o_wr_probe <= i_wr_req && !low_cost;
        o_wr_block_write <= i_wr_req && low_cost;
        o_rd_probe <= i_rd_req;
        // The pack flag follows the next state of the request while fewer than two longwords are counted, so it rises in
        // the cycle after the request is written and falls in the cycle after the second longword write request or the queue load, whichever comes first.
        o_pack_next <= nxt_pack_ff && (nxt_pack_cnt_ff != 2'h2) && (i_wr_is_io || i_wr_is_unlock || 1'b1);
        if (i_wr_req && low_cost) begin
            o_data_address_bit <= (i_wr_byte_mask[7:0] == 8'h00);
            o_write_byte_mask_pins <= (i_wr_byte_mask[7:0] == 8'h00) ? i_wr_byte_mask[15:8] : i_wr_byte_mask[7:0];
            o_data_write_enable_pins <= (i_wr_byte_mask[7:0] == 8'h00) ? 2'h0 :
                {|i_wr_byte_mask[15:12], |i_wr_byte_mask[11:8]};
        end else if (!low_cost) begin
            o_data_write_enable_pins <= 2'h0;
            o_write_byte_mask_pins <= 8'h00;
            o_data_address_bit <= 1'b0;
        end
    end
end

// Write check bits: software register or generator.
always @(posedge i_sys_clk) begin
    if (i_reset)
        o_write_check_bits <= 14'h0000;
    else if (ctl_ff[`CTL_SW_CHECK_BIT])
        o_write_check_bits <= {swck_ff[13:7], swck_ff[6:0]};
    else
        o_write_check_bits <= i_gen_check_bits;
end

// Register read data; write-only registers read as zero.
always @(posedge i_sys_clk) begin
    if (i_reset) begin
        o_reg_rdata <= 32'h00000000;
    end else if (i_reg_rd) begin
        case (i_reg_addr)
            `REG_BUS_UNIT_ERROR_STATUS: o_reg_rdata <= {17'h00000, stat_ff};
            `REG_FILL_SYNDROME: o_reg_rdata <= {18'h00000, syn_ff};
            `REG_TAG_CAPTURE: o_reg_rdata <= {{(32-TAG_W){1'b0}}, tag_ff};
            `REG_STORE_COND_OUTCOME: o_reg_rdata <= {29'h00000000, stxc_ff, 2'h0};
            default: o_reg_rdata <= 32'h00000000;
        endcase
    end
end

endmodule // cache_bus_unit

// ### cache_bus_unit_props.sv
// Port-level checks of the cache bus unit.
`timescale 1ns/1ps
module cache_bus_unit_props (
    // Clock, reset and requests.
    input wire i_sys_clk,
    input wire i_reset,
    input wire i_reg_wr,
    input wire [7:0] i_reg_addr,
    input wire i_wr_req,
    input wire [15:0] i_wr_byte_mask,
    input wire i_rd_req,
    input wire i_lock_read_failed,
    input wire i_wr_qw_queued,
    // Observed outputs.
    input wire o_wr_probe,
    input wire o_wr_block_write,
    input wire o_rd_probe,
    input wire o_pack_next,
    input wire o_fetch_lockout,
    input wire o_cache_cycle_enable,
    input wire [7:0] o_write_byte_mask_pins,
    input wire o_data_address_bit,
    input wire [1:0] o_data_write_enable_pins
);
    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (i_reset);

    // A write request answered by a block write strobe.
    sequence s_lc_write;
        i_wr_req ##1 o_wr_block_write;
    endsequence
    property p_one_kind; i_wr_req |=> o_wr_probe != o_wr_block_write; endproperty
    property p_mask; s_lc_write |-> o_write_byte_mask_pins == ((|$past(i_wr_byte_mask[7:0])) ?
        $past(i_wr_byte_mask[7:0]) : $past(i_wr_byte_mask[15:8])) && o_data_address_bit == !(|$past(i_wr_byte_mask[7:0]));
    endproperty
    property p_enables; s_lc_write |-> o_data_write_enable_pins == ((|$past(i_wr_byte_mask[7:0])) ?
        {|$past(i_wr_byte_mask[15:12]), |$past(i_wr_byte_mask[11:8])} : 2'h0); endproperty
    property p_quiet; o_wr_probe |-> o_data_write_enable_pins == 2'h0 && o_write_byte_mask_pins == 8'h00; endproperty
    property p_rd_probe; i_rd_req |=> o_rd_probe; endproperty
    property p_cycle; o_cache_cycle_enable |=> !o_cache_cycle_enable ##[1:3] o_cache_cycle_enable; endproperty
    property p_lock; i_lock_read_failed |=> o_fetch_lockout; endproperty
    property p_unlock; i_reg_wr && i_reg_addr == 8'hac && !i_lock_read_failed |=> !o_fetch_lockout; endproperty
    property p_pack; i_reg_wr && i_reg_addr == 8'ha5 |=> o_pack_next; endproperty
    property p_unpack; i_wr_qw_queued && !(i_reg_wr && i_reg_addr == 8'ha5) |=> !o_pack_next; endproperty

    a_one_kind: assert property (p_one_kind) else $error("write not answered by exactly one strobe");
    a_mask: assert property (p_mask) else $error("mask pins or address bit wrong");
    a_enables: assert property (p_enables) else $error("write enable code wrong");
    a_quiet: assert property (p_quiet) else $error("mask pins active in normal mode");
    a_rd_probe: assert property (p_rd_probe) else $error("read did not probe");
    a_cycle: assert property (p_cycle) else $error("cache cycle spacing out of range");
    a_lock: assert property (p_lock) else $error("lockout not set");
    a_unlock: assert property (p_unlock) else $error("lockout not cleared");
    a_pack: assert property (p_pack) else $error("pack request not set");
    a_unpack: assert property (p_unpack) else $error("pack request not cleared");
endmodule // cache_bus_unit_props

bind cache_bus_unit cache_bus_unit_props u_props (.*);

// ### cache_bus_unit_regs.vh
// Register offsets, field positions, encodings and reset values of the cache bus unit control block.
`ifndef CACHE_BUS_UNIT_REGS_VH
`define CACHE_BUS_UNIT_REGS_VH

// Processor register addresses (8-bit register numbers).
`define REG_BUS_UNIT_CONTROL 8'ha0
`define REG_BUS_UNIT_ERROR_STATUS 8'ha1
`define REG_FILL_SYNDROME 8'ha2
`define REG_SW_CHECK_BITS 8'ha3
`define REG_TAG_CAPTURE 8'ha4
`define REG_STORE_COND_OUTCOME 8'hac
`define REG_QUADWORD_PACK_REQUEST_REQUEST 8'ha5

// Control register field positions.
`define CTL_ECC_BIT 1
`define CTL_SPD_LO 4
`define CTL_SPD_HI 5
`define CTL_LOW_COST_BIT 13
`define CTL_SW_CHECK_BIT 19
`define CTL_SIZE_LO 20
`define CTL_SIZE_HI 22
`define CTL_RESET 32'h00000000

// Error status bit positions.
`define STAT_HERR 0
`define STAT_SERR 1
`define STAT_TPERR 2
`define STAT_TCPERR 3
`define STAT_BIU_SEO 7
`define STAT_FILL_ECC 8
`define STAT_FILL_CRD 9
`define STAT_DPERR 10
`define STAT_FILL_SEO 14

// Store conditional outcome bit.
`define STXC_FAIL_BIT 2

// Cache speed encodings (CPU cycles per cache access).
`define SPD_2X 2'h0
`define SPD_3X 2'h1
`define SPD_4X 2'h2

// Syndrome and check-bit field width per longword.
`define HALF_CHECK_W 7

`endif

// ### sys_logic_model.sv
// Behavioural system logic and cache RAM on the far side of the bus unit.
`timescale 1ns/1ps
module sys_logic_model (
    // Mask pins from the bus unit.
    input wire [7:0] i_mask,
    input wire i_addr_bit,
    input wire [1:0] i_we,
    // Data held in the cache RAMs.
    input wire [127:0] i_data,
    // Derived byte enables and check pins.
    output wire [15:0] o_byte_en,
    output wire [27:0] o_check
);
    wire [7:0] other = {{4{i_we[1]}}, {4{i_we[0]}}};
    reg [27:0] chk_ff;
    integer k;

    // Sixteen byte enables built from the mask, address bit and write enables.
    assign o_byte_en = i_addr_bit ? {i_mask, other} : {other, i_mask};
    // Byte parity on the check pins; unused pins follow inverted data so they are never steady.
    always @* begin
        chk_ff = ~i_data[27:0];
        for (k = 0; k < 16; k = k + 1)
            chk_ff[(k / 4) * 7 + k % 4] = ^i_data[k * 8 +: 8];
    end
    assign o_check = chk_ff;
endmodule // sys_logic_model

// ### testbench.sv
// Self-checking bench of the cache bus unit against a bench model.
`timescale 1ns/1ps
module testbench;
    logic i_sys_clk = 0, i_reset = 1, i_reg_wr = 0, i_reg_rd = 0, i_wr_req = 0, i_wr_is_io = 0, i_wr_is_unlock = 0;
    logic i_wr_qw_queued = 0, i_rd_req = 0, i_tag_probe_done = 0, i_err_hard = 0, i_err_soft = 0, i_err_tag_par = 0;
    logic i_err_tagctl_par = 0, i_err_fill_ecc = 0, i_err_fill_crd = 0, i_err_fill_par = 0, i_stxc_done = 0;
    logic i_stxc_failed = 0, i_lock_read_failed = 0;
    logic [7:0] i_reg_addr = 0;
    logic [31:0] i_reg_wdata = 0, s;
    logic [15:0] i_wr_byte_mask = 0;
    logic [14:0] i_tag_probe_value = 0;
    logic [5:0] i_req_tag_bits = 0, i_ram_tag_bits = 0;
    logic [13:0] i_fill_syndrome = 0, i_gen_check_bits = 0;
    logic [127:0] ram_data = 0;
    wire [31:0] o_reg_rdata;
    wire [27:0] i_check_pins;
    wire [15:0] byte_en;
    wire [13:0] o_write_check_bits;
    wire [7:0] o_write_byte_mask_pins;
    wire [3:0] o_longword_parity, o_cache_size_kb_log;
    wire [1:0] o_data_write_enable_pins;
    wire o_wr_probe, o_wr_block_write, o_pack_next, o_rd_probe, o_tag_upper_match, o_fetch_lockout;
    wire o_data_address_bit, o_cache_cycle_enable;
    integer n_errors = 0, cmp_count = 0, seed = 2294, k, n, m, e;

    cache_bus_unit DUT (.*);
    sys_logic_model sys (.i_mask(o_write_byte_mask_pins), .i_addr_bit(o_data_address_bit),
        .i_we(o_data_write_enable_pins), .i_data(ram_data), .o_byte_en(byte_en), .o_check(i_check_pins));

    // Clock at 100 ns period.
    always #50 i_sys_clk = ~i_sys_clk;

    // Bus and pin helpers; all drives land 10 ns after a rising edge.
    task tick(input integer c);
        repeat (c) @(posedge i_sys_clk);
        #10;
    endtask
    task chk(input [31:0] got, input [31:0] exp);
        cmp_count = cmp_count + 1;
        if (got !== exp) begin
            n_errors = n_errors + 1;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task wr(input [7:0] a, input [31:0] v);
        i_reg_wr = 1;
        i_reg_addr = a;
        i_reg_wdata = v;
        tick(1);
        i_reg_wr = 0;
        tick(1);
    endtask
    task rd(input [7:0] a, input [31:0] exp);
        i_reg_rd = 1;
        i_reg_addr = a;
        tick(1);
        i_reg_rd = 0;
        chk(o_reg_rdata, exp);
        tick(1);
    endtask
    task wreq(input [15:0] v);
        i_wr_req = 1;
        i_wr_byte_mask = v;
        i_wr_is_io = $random(seed);
        tick(1);
        i_wr_req = 0;
    endtask
    task ecc(input [13:0] v);
        i_err_fill_ecc = 1;
        i_fill_syndrome = v;
        tick(1);
        i_err_fill_ecc = 0;
    endtask
    task probe(input [14:0] v);
        i_tag_probe_done = 1;
        i_tag_probe_value = v;
        tick(1);
        i_tag_probe_done = 0;
    endtask
    task test_done;
        $display("errors=%0d compares=%0d", n_errors, cmp_count);
        if (n_errors == 0 && cmp_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // Watchdog against a hang.
    initial begin
        repeat (3000) @(posedge i_sys_clk);
        n_errors = n_errors + 1;
        test_done;
    end

    // Main sequence.
    initial begin
        tick(5);
        i_reset = 0;
        chk(o_cache_size_kb_log, 7);
        for (k = 0; k < 7; k = k + 1) begin
            wr(8'ha0, k * 32'h100000 + (k % 3) * 16);
            i_req_tag_bits = $random(seed);
            i_ram_tag_bits = i_req_tag_bits ^ (1 << (k * 5 % 6));
            tick(6);
            chk(o_cache_size_kb_log, 7 + k);
            chk(o_tag_upper_match, ((63 << k) & (1 << (k * 5 % 6))) == 0);
            for (n = 0; n < 9 && !o_cache_cycle_enable; n = n + 1)
                tick(1);
            tick(1);
            for (n = 1; n < 9 && !o_cache_cycle_enable; n = n + 1)
                tick(1);
            chk(n, 2 + k % 3);
        end
        wr(8'ha0, 32'h2000);
        for (k = 0; k < 10; k = k + 1) begin
            m = (k == 0) ? 'h0f00 : $random(seed);
            ram_data = {$random(seed), $random(seed), $random(seed), $random(seed)};
            wreq(m);
            n = m & 255;
            e = (m >> 8) & 255;
            chk(o_wr_block_write, 1);
            chk(o_write_byte_mask_pins, n ? n : e);
            chk(o_data_address_bit, n == 0);
            chk(o_data_write_enable_pins, n ? (e > 15) * 2 + ((e & 15) > 0) : 0);
            chk(byte_en, n ? n + (((e & 15) ? 15 : 0) + ((e > 15) ? 240 : 0)) * 256 : e * 256);
            i_rd_req = 1;
            tick(1);
            chk(o_rd_probe, 1);
            i_rd_req = 0;
            tick(3);
            chk(o_longword_parity, {^ram_data[127:96], ^ram_data[95:64], ^ram_data[63:32], ^ram_data[31:0]});
        end
        wr(8'ha0, 2);
        wreq($random(seed));
        chk(o_wr_probe, 1);
        chk(o_data_write_enable_pins, 0);
        tick(3);
        chk(o_longword_parity, 0);
        s = $random(seed);
        ecc(s);
        rd(8'ha2, s & 16383);
        ecc(~s);
        rd(8'ha2, s & 16383);
        rd(8'ha2, s & 16383);
        rd(8'ha1, 32'h4100);
        wr(8'ha1, 32'h4700);
        ecc(~s);
        rd(8'ha2, ~s & 16383);
        wr(8'ha1, 32'h478f);
        probe(s);
        rd(8'ha4, s & 32767);
        i_err_tag_par = 1;
        tick(1);
        i_err_tag_par = 0;
        rd(8'ha1, 32'h4);
        probe(~s);
        rd(8'ha4, s & 32767);
        wr(8'ha1, 32'h8f);
        probe(~s);
        rd(8'ha4, ~s & 32767);
        wr(8'ha0, 32'h80000);
        wr(8'ha3, s);
        i_gen_check_bits = ~s;
        tick(1);
        chk(o_write_check_bits, s & 16383);
        rd(8'ha3, 0);
        rd(8'h77, 0);
        wr(8'ha0, 0);
        tick(1);
        chk(o_write_check_bits, ~s & 16383);
        for (k = 0; k < 2; k = k + 1) begin
            i_stxc_done = 1;
            i_stxc_failed = k;
            tick(1);
            i_stxc_done = 0;
            rd(8'hac, k * 4);
        end
        i_lock_read_failed = 1;
        tick(1);
        i_lock_read_failed = 0;
        chk(o_fetch_lockout, 1);
        wr(8'hac, 0);
        chk(o_fetch_lockout, 0);
        wr(8'ha5, 0);
        wreq(1);
        chk(o_pack_next, 1);
        i_wr_qw_queued = 1;
        tick(1);
        i_wr_qw_queued = 0;
        chk(o_pack_next, 0);
        test_done;
    end
endmodule // testbench
